// ===== bench/nar_chip_model.sv
`timescale 1ns/1ps
module nar_chip_model (
    input  wire       clock,              // system clock
    input  wire [5:0] serAddr,            // serial register select
    input  wire [7:0] serWdata,           // serial write byte
    input  wire       serRd,              // serial read strobe
    input  wire       serWr,              // serial write strobe
    output wire [7:0] serRdata,           // serial read byte
    input  wire [2:0] ethAddr,            // ethernet register select
    input  wire [7:0] ethWdata,           // ethernet write byte
    input  wire       ethRd,              // ethernet read strobe
    input  wire       ethWr,              // ethernet write strobe
    output wire [7:0] ethRdata,           // ethernet read byte
    output reg  [7:0] ethTxStat = 8'h00,  // internal transmit status
    output reg  [7:0] ethRxStat = 8'h00   // internal receive status
);
    reg [7:0] sm [0:63];
    reg [7:0] em [0:7];
    reg [7:0] junk = 8'h5A;
    // undriven read lines toggle so a late sample cannot match by luck
    always @(posedge clock) begin
        junk <= ~junk;
        if (serWr) sm[serAddr] <= serWdata;
        if (ethWr) em[ethAddr] <= ethWdata;
    end
    assign serRdata = serRd ? sm[serAddr] : junk;
    assign ethRdata = !ethRd ? junk : ethAddr == 3'h6 ? ethRxStat :
                      ethAddr == 3'h7 ? ethTxStat : em[ethAddr];
endmodule

// ===== bench/nar_io_props.sv
`timescale 1ns/1ps
module nar_io_props #(
    parameter [31:0] BOARD_IDENTIFIER = 32'h0000_00A5 // arbitrary value
) (
    input wire        clock,      // system clock
    input wire        rst_n,      // async reset, active low
    input wire        ioReq,      // io request
    input wire        ioWrite,    // write flag
    input wire [8:0]  ioAddr,     // io address
    input wire        ioAck,      // answer
    input wire [31:0] ioRdata,    // read data
    input wire        busIrq,     // interrupt line
    input wire        serRd,      // serial read strobe
    input wire        serWr,      // serial write strobe
    input wire        serIrq,     // serial interrupt
    input wire        dmaHalt,    // stop pulse
    input wire        dmaRestart, // retransmit pulse
    input wire        txGo,       // transmitter run
    input wire        loopback,   // loop enable
    input wire        xcvrEnable  // transceiver enable
);
    reg [1:0] bsy;
    reg [2:0] grp;
    reg       wrTk;
    wire      take = ioReq && bsy == 2'h0;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bsy  <= 2'h0;
            grp  <= 3'h0;
            wrTk <= 1'b0;
        end else begin
            bsy <= take ? 2'h2 : (bsy == 2'h0 ? 2'h0 : bsy - 2'h1);
            if (take) begin
                grp  <= ioAddr[8:6];
                wrTk <= ioWrite;
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_ack_latency: assert property (take |-> !ioAck ##1 !ioAck ##1 ioAck)
        else $error("ack not two cycles after take");
    chk_ack_pulse: assert property (ioAck |=> !ioAck)
        else $error("ack longer than one cycle");
    chk_serial_strobe: assert property (take && !ioWrite && ioAddr[8:6] == 3'h4 |=> serRd)
        else $error("serial read strobe missing");
    chk_no_stray: assert property (take && ioAddr[8:6] != 3'h4 |=> !serRd && !serWr)
        else $error("serial strobe on other group");
    chk_upper_zero: assert property (ioAck && grp == 3'h4 && !wrTk |-> ioRdata[31:8] == 24'h0)
        else $error("serial upper bits not zero");
    chk_board_identifier: assert property (ioAck && grp == 3'h7 && !wrTk |-> ioRdata == BOARD_IDENTIFIER)
        else $error("board identifier wrong");
    chk_serial_flag: assert property (serIrq |=> busIrq)
        else $error("serial interrupt not raised");
    chk_loop_tie: assert property (loopback != xcvrEnable)
        else $error("loopback not inverse of transceiver");
    chk_restart_excl: assert property (dmaRestart |-> !dmaHalt)
        else $error("halt and restart together");
    chk_halt_flag: assert property (dmaHalt |-> ##[0:1] busIrq)
        else $error("halt without interrupt");
    chk_halt_idle: assert property (dmaHalt |=> !txGo)
        else $error("transmitter runs after halt");
    cover property (take && ioWrite);
    cover property (dmaHalt);
    cover property (serIrq && busIrq);
endmodule
bind nar_io_regs nar_io_props #(.BOARD_IDENTIFIER(BOARD_IDENTIFIER)) nar_io_props_inst (.*);

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam [31:0] BID = 32'h0000_005A; // arbitrary value
    logic clock = 0, rst_n = 0, ioReq = 0, ioWrite = 0, ioParityBad = 0, dmaRdValid = 0;
    logic serIrq = 0, ethIrq = 0, txAttemptEnd = 0, rxPacketDone = 0;
    logic [8:0] ioAddr = 9'h000;
    logic [31:0] ioWdata = 32'h0000_0000, dmaRdata = 32'h0000_0000, ioRdata, dmaWdata, rd, r;
    logic ioAck, busIrq, serRd, serWr, ethRd, ethWr, dmaWr, dmaHalt, dmaRestart;
    logic txGo, rxAccept, byteSeqSelect, loopback, xcvrEnable;
    logic [7:0] serWdata, serRdata, ethWdata, ethRdata, ethTxStat, ethRxStat;
    logic [7:0] termReady, rxEndStatus, txs = 8'h00, rxs = 8'h00;
    logic [5:0] serAddr;
    logic [2:0] ethAddr;
    logic [1:0] dmaSel;
    logic [3:0] rxEndReadPtr, ctrl = 4'h0, rdp = 4'h0, wrp = 4'h0, ints = 4'h0;
    int fails = 0, checks = 0, halts = 0, rsts = 0;
    nar_io_regs #(.BOARD_IDENTIFIER(BID)) nar_io_regs_inst (.*);
    nar_chip_model nar_chip_model_inst (.*);
    always #2 clock = ~clock;
    always @(posedge clock) begin
        halts += dmaHalt;
        rsts += dmaRestart;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request stands until the answer is seen
    task automatic io(input logic w, input logic [8:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input string nm);
        int n;
        @(posedge clock); #1;
        ioReq = 1; ioWrite = w; ioAddr = a; ioWdata = d;
        n = 0;
        while (ioAck !== 1'b1 && n < 8) begin
            @(posedge clock); #1;
            n++;
        end
        chk({nm, " ack"}, ioAck, 1);
        rd = ioRdata;
        @(posedge clock); #1;
        ioReq = 0;
        chk(nm, rd, exp);
    endtask
    function automatic logic [31:0] st();
        return {txs, rxs, rdp, wrp, ctrl, ints};
    endfunction
    task automatic rs(input logic a0);
        io(0, {3'h5, 5'h00, a0}, 0, st(), "status");
        if (!a0) ints = {3'h0, serIrq};
    endtask
    task automatic pulse(ref logic s);
        @(posedge clock); #1;
        s = 1;
        @(posedge clock); #1;
        s = 0;
        repeat (2) @(posedge clock); #1;
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #(4 * 20000);
        fails++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        close_out;
    end
    initial begin
        void'($urandom(84253));
        repeat (6) @(posedge clock);
        #1 rst_n = 1;
        chk("loopback", loopback, 1);
        rs(1);
        r = $urandom;
        io(0, {3'h7, r[5:0]}, 0, BID, "board_identifier");
        io(1, {3'h7, r[11:6]}, r, 0, "id write");
        io(0, {3'h3, r[17:12]}, 0, 0, "unused");
        io(1, 9'h000, r, 0, "term write");
        chk("term", termReady, r[7:0]);
        for (int i = 24; i < 32; i++)
            io(0, 9'h180 + 9'(i), 0, (32'hAA55_00FF >> (8 * (i % 4))) & 32'h0000_00FF, "rom");
        io(1, 9'h083, r, 0, "eth write");
        chk("eth byte", nar_chip_model_inst.em[3], r[7:0]);
        io(0, 9'h083, 0, 0, "eth sel 3");
        $display("test decode done");
        r = $urandom;
        io(1, {3'h5, r[5:0]}, r, 0, "ctrl");
        ctrl = r[7:4];
        rs(1);
        chk("byte seq", byteSeqSelect, ctrl[3]);
        chk("xcvr", xcvrEnable, ctrl[2]);
        chk("tx go", txGo, ctrl[1]);
        chk("rx accept", rxAccept, 0);
        ctrl = 4'h0;
        io(1, 9'h140, 0, 0, "ctrl");
        $display("test control done");
        for (int i = 0; i < 3; i++) begin
            r = $urandom;
            io(1, {3'h4, r[13:8]}, r, 0, "ser write");
            chk("ser byte", nar_chip_model_inst.sm[r[13:8]], r[7:0]);
            repeat (113) @(posedge clock);
            io(0, {3'h4, r[13:8]}, 0, {24'h0, r[7:0]}, "ser read");
            repeat (113) @(posedge clock);
        end
        #1 serIrq = 1;
        repeat (2) @(posedge clock); #1;
        chk("irq", busIrq, 1);
        ints[0] = 1;
        rs(1);
        rs(0);
        serIrq = 0;
        rs(0);
        rs(0);
        chk("irq", busIrq, 0);
        $display("test serial done");
        ioParityBad = 1;
        io(0, 9'h1C0, 0, BID, "board_identifier");
        ioParityBad = 0;
        ints[1] = 1;
        rs(0);
        dmaRdValid = 1; ioParityBad = 1;
        @(posedge clock); #1;
        dmaRdValid = 0;
        ints[1] = 1;
        rs(0);
        ioParityBad = 0;
        rs(0);
        $display("test parity done");
        repeat (2) begin
            io(1, 9'h043, 32'h0000_0100, 0, "rx length");
            wrp++;
        end
        chk("dma", {dmaSel, dmaWdata[15:0]}, {2'h3, 16'h0100});
        ctrl = 4'h1;
        io(1, 9'h140, 32'h0000_0010, 0, "ctrl");
        @(posedge clock); #1;
        chk("rx accept", rxAccept, 1);
        repeat (2) begin
            pulse(rxPacketDone);
            rdp++;
        end
        ints[2] = 1;
        rs(0);
        chk("rx accept", rxAccept, 0);
        pulse(rxPacketDone);
        rs(0);
        repeat (15) begin
            io(1, 9'h043, 0, 0, "rx length");
            wrp++;
        end
        rs(1);
        $display("test receive done");
        r = $urandom;
        nar_chip_model_inst.ethRxStat = r[7:0];
        io(1, 9'h087, 32'h0000_000D, 0, "tx mask");
        ctrl = 4'h2;
        io(1, 9'h140, 32'h0000_0020, 0, "ctrl");
        @(posedge clock); #1;
        chk("tx go", txGo, 1);
        nar_chip_model_inst.ethTxStat = 8'h02;
        pulse(txAttemptEnd);
        chk("tx go", txGo, 1);
        chk("irq", busIrq, 0);
        nar_chip_model_inst.ethTxStat = 8'h08;
        pulse(txAttemptEnd);
        chk("tx go", txGo, 0);
        chk("halt restart", {halts[3:0], rsts[3:0]}, 8'h11);
        ints[3] = 1;
        io(0, 9'h087, 0, 32'h0000_0008, "eth status");
        txs = 8'h08;
        rxs = r[7:0];
        rs(0);
        nar_chip_model_inst.ethTxStat = r[15:8];
        nar_chip_model_inst.ethRxStat = r[23:16];
        ethIrq = 1;
        repeat (2) @(posedge clock); #1;
        ethIrq = 0;
        txs = r[15:8];
        rxs = r[23:16];
        rs(0);
        chk("end status", {rxEndReadPtr, rxEndStatus}, {rdp, rxs});
        $display("test transmit done");
        close_out;
    end
endmodule

// ===== hw/nar_addr_rom.v
`timescale 1ns/1ps
module nar_addr_rom #(
    parameter [47:0] STATION_ADDR = 48'h0000_0000_0001, // per-board value, arbitrary default
    parameter [15:0] ADDR_SUM     = 16'h0000            // checksum of the six bytes
) (
    input  wire [4:0] index,  // byte select
    output reg  [7:0] data    // selected byte
);
    wire [63:0] fwd;
    wire [63:0] rev;
    wire [63:0] tst;
    assign fwd = {ADDR_SUM[7:0], ADDR_SUM[15:8], STATION_ADDR[7:0], STATION_ADDR[15:8],
                  STATION_ADDR[23:16], STATION_ADDR[31:24], STATION_ADDR[39:32],
                  STATION_ADDR[47:40]};
    assign tst = 64'hAA55_00FF_AA55_00FF;

    // second copy is the first one with byte order reversed
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gRev
            assign rev[8*g+7:8*g] = fwd[8*(7-g)+7:8*(7-g)];
        end
    endgenerate

    always @* begin
        case (index[4:3])
            2'h0:    data = fwd[8*index[2:0] +: 8];
            2'h1:    data = rev[8*index[2:0] +: 8];
            2'h2:    data = fwd[8*index[2:0] +: 8];
            default: data = tst[8*index[2:0] +: 8];
        endcase
    end
endmodule

// ===== hw/nar_desc_queue.v
`timescale 1ns/1ps
`include "nar_io_map.vh"
module nar_desc_queue #(
    parameter PTR_W = 4
) (
    input  wire             clock,      // system clock
    input  wire             rst_n,      // async reset, active low
    input  wire             readAdv,    // hardware finished a buffer
    input  wire             writeAdv,   // software wrote a receive length
    output reg  [PTR_W-1:0] readPtr,    // descriptor read pointer
    output reg  [PTR_W-1:0] writePtr,   // descriptor write pointer
    output wire             empty,      // no descriptor pending
    output wire             full        // one slot left unused
);
    // no overrun guard: software keeps at most fifteen descriptors queued
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readPtr  <= `NAR_PTR_RESET;
            writePtr <= `NAR_PTR_RESET;
        end else begin
            if (readAdv)
                readPtr <= readPtr + 1'b1;
            if (writeAdv)
                writePtr <= writePtr + 1'b1;
        end
    end
    assign empty = (readPtr == writePtr);
    assign full  = ((writePtr + 1'b1) == readPtr);
endmodule

// ===== hw/nar_io_map.vh
`ifndef NAR_IO_MAP_VH
`define NAR_IO_MAP_VH

// register group codes on address bits 8-6
`define NAR_GRP_TERM_READY  3'h0
`define NAR_GRP_DMA         3'h1
`define NAR_GRP_ETH_CTRL    3'h2
`define NAR_GRP_UNUSED      3'h3
`define NAR_GRP_SERIAL      3'h4
`define NAR_GRP_STATUS      3'h5
`define NAR_GRP_ADDR_ROM    3'h6
`define NAR_GRP_BOARD_IDENTIFIER    3'h7

// address field positions
`define NAR_GRP_MSB         8
`define NAR_GRP_LSB         6
`define NAR_SUB_MSB         5
`define NAR_ROM_IDX_MSB     4
`define NAR_ETH_SEL_MSB     2
`define NAR_DMA_SEL_MSB     1

// selections inside the ethernet and dma groups
`define NAR_ETH_RX_STATUS   3'h6
`define NAR_ETH_TX_STATUS   3'h7
`define NAR_DMA_RX_LENGTH   2'h3

// status word field positions
`define NAR_ST_TX_LSB       24
`define NAR_ST_RX_LSB       16
`define NAR_ST_RDPTR_LSB    12
`define NAR_ST_WRPTR_LSB    8
`define NAR_ST_CTRL_LSB     4
`define NAR_ST_INTS_LSB     0
`define NAR_TX_ERR_MSB      2

// control bits inside the written data word
`define NAR_CTRL_BYTESEQ    7
`define NAR_CTRL_XCVR       6
`define NAR_CTRL_TXEN       5
`define NAR_CTRL_RXEN       4

// interrupt flag positions
`define NAR_INT_TX          3
`define NAR_INT_RX          2
`define NAR_INT_PARITY      1
`define NAR_INT_SERIAL      0

// reset values
`define NAR_CTRL_RESET      4'h0
`define NAR_INTS_RESET      4'h0
`define NAR_PTR_RESET       4'h0
`define NAR_STAT_RESET      8'h00

`endif

// ===== hw/nar_io_regs.v
// Overview of operation
// - serial registers appear as words, upper zero
// - serial flag clears on read once released
// - decode nine address bits, group in 8-6
// - group codes map the eight register groups
// - group 7 reads fixed board identifier
// - group 6 reads one of 32 rom bytes
// - status writes change only control field
// - copy controller status on interrupt, status read
// - read pointer advances before receive flag sets
// - queue empty on equal, full on wrap
// - four control bits readable, reset clears them
// - byte sequence bit orders bytes in words
// - transceiver off loops transmit to receive
// - transmit one packet, then idle until cleared
// - receive only when enabled and queue nonempty
// - interrupt line from flags; status reads with address bit 0 low clear them
// - transmit flag on fatal error, or on finish only when its status bit is masked
// - receive flag per completion, completions merge
// - parity flag on bad parity while receiving
// - ethernet group selects eight byte registers
// - masked error halts, unmasked error retransmits
`timescale 1ns/1ps
`include "nar_io_map.vh"
module nar_io_regs #(
    parameter [31:0] BOARD_IDENTIFIER     = 32'h0000_00A5,       // arbitrary identifier value
    parameter [47:0] STATION_ADDR = 48'h0000_0000_0001,  // arbitrary default
    parameter [15:0] ADDR_SUM     = 16'h0000,
    parameter        PTR_W        = 4
) (
    input  wire        clock,          // system clock
    input  wire        rst_n,          // async reset, active low
    input  wire        ioReq,          // io access request
    input  wire        ioWrite,        // 1 write, 0 read
    input  wire [8:0]  ioAddr,         // io address low bits
    input  wire [31:0] ioWdata,        // io write data
    input  wire        ioParityBad,    // bad parity seen on bus data
    input  wire        dmaRdValid,     // dma read data on bus this cycle
    output reg         ioAck,          // access answered
    output reg  [31:0] ioRdata,        // read data with ack
    output reg         busIrq,         // bus interrupt line
    output reg  [5:0]  serAddr,        // serial controller register select
    output reg  [7:0]  serWdata,       // serial write byte
    output reg         serRd,          // serial read strobe
    output reg         serWr,          // serial write strobe
    input  wire [7:0]  serRdata,       // serial read byte
    input  wire        serIrq,         // serial controller interrupt
    output reg  [2:0]  ethAddr,        // ethernet register select
    output reg  [7:0]  ethWdata,       // ethernet write byte
    output reg         ethRd,          // ethernet read strobe
    output reg         ethWr,          // ethernet write strobe
    input  wire [7:0]  ethRdata,       // ethernet read byte
    input  wire        ethIrq,         // ethernet controller interrupt
    input  wire [7:0]  ethTxStat,      // controller internal transmit status
    input  wire [7:0]  ethRxStat,      // controller internal receive status
    output reg  [1:0]  dmaSel,         // dma register select
    output reg  [31:0] dmaWdata,       // dma register write data
    output reg         dmaWr,          // dma register write strobe
    input  wire [31:0] dmaRdata,       // dma register read data
    output reg  [7:0]  termReady,      // terminal ready lines
    input  wire        txAttemptEnd,   // transmit attempt concluded
    input  wire        rxPacketDone,   // ending status stored in buffer
    output reg         dmaHalt,        // stop transmit dma
    output reg         dmaRestart,     // retransmit from saved values
    output reg         txGo,           // transmitter may run
    output reg         rxAccept,       // receiver may copy packets
    output reg         byteSeqSelect,  // byte order within a word
    output reg         loopback,       // transmit looped to receive
    output reg         xcvrEnable,     // transceiver drive enable
    output reg  [7:0]  rxEndStatus,    // receive status for ending status
    output reg  [3:0]  rxEndReadPtr    // read pointer for ending status
);
    localparam ST_IDLE   = 2'h0;
    localparam ST_ACCESS = 2'h1;
    localparam ST_DONE   = 2'h2;

    reg  [1:0]  state;
    reg         curWrite;
    reg  [8:0]  curAddr;
    reg  [31:0] curWdata;
    reg  [3:0]  ctrl;
    reg  [3:0]  ints;
    reg  [7:0]  txStatCopy;
    reg  [7:0]  rxStatCopy;
    reg  [7:0]  txCommand;
    reg         ethIrqLast;
    reg         txFinished;
    reg         rxDoneLate;
    reg  [3:0]  next_ints;
    reg  [31:0] rdMux;
    wire [2:0]  grp;
    wire [PTR_W-1:0] readPtr;
    wire [PTR_W-1:0] writePtr;
    wire        qEmpty;
    wire        qFull;
    wire [7:0]  romByte;
    wire [31:0] statusWord;
    wire        take;
    wire        inAccess;
    wire        statusRead;
    wire        ethStatRead;
    wire        rxLenWrite;
    wire        readAdv;
    wire        txFatal;
    wire        ethIrqRise;
    wire        txErrEvent;
    wire        txDone;

    assign grp      = curAddr[`NAR_GRP_MSB:`NAR_GRP_LSB];
    assign take     = ioReq && (state == ST_IDLE);
    assign inAccess = (state == ST_ACCESS);

    // reads with address bit 0 set look at the flags without consuming them
    assign statusRead  = inAccess && !curWrite && (grp == `NAR_GRP_STATUS)
                         && !curAddr[0];
    assign ethStatRead = ethRd && (ethAddr == `NAR_ETH_RX_STATUS ||
                                   ethAddr == `NAR_ETH_TX_STATUS);
    assign rxLenWrite  = dmaWr && (dmaSel == `NAR_DMA_RX_LENGTH);
    // rise only, so a held line cannot keep overwriting the copies
    assign ethIrqRise  = ethIrq && !ethIrqLast;
    assign txFatal     = |(ethTxStat & txCommand);

    // rxAccept lags an advance by a cycle; guard on live pointers
    assign readAdv     = rxPacketDone && rxAccept && !qEmpty;

    // clean send with good-packet unmasked: no retransmit, no flag
    assign txErrEvent  = |ethTxStat[`NAR_TX_ERR_MSB:0];
    assign txDone      = txAttemptEnd && txGo && (txFatal || !txErrEvent);

    assign statusWord = {txStatCopy, rxStatCopy, readPtr, writePtr, ctrl, ints};

    nar_desc_queue #(
        .PTR_W    (PTR_W)
    ) uQueue (
        .clock    (clock),
        .rst_n    (rst_n),
        .readAdv  (readAdv),
        .writeAdv (rxLenWrite),
        .readPtr  (readPtr),
        .writePtr (writePtr),
        .empty    (qEmpty),
        .full     (qFull)
    );

    nar_addr_rom #(
        .STATION_ADDR (STATION_ADDR),
        .ADDR_SUM     (ADDR_SUM)
    ) uRom (
        .index (curAddr[`NAR_ROM_IDX_MSB:0]),
        .data  (romByte)
    );

    // access sequencer: take, strobe out, answer
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            curWrite <= 1'b0;
            curAddr  <= 9'h000;
            curWdata <= 32'h0000_0000;
            ioAck    <= 1'b0;
            ioRdata  <= 32'h0000_0000;
            serAddr  <= 6'h00;
            serWdata <= 8'h00;
            serRd    <= 1'b0;
            serWr    <= 1'b0;
            ethAddr  <= 3'h0;
            ethWdata <= 8'h00;
            ethRd    <= 1'b0;
            ethWr    <= 1'b0;
            dmaSel   <= 2'h0;
            dmaWdata <= 32'h0000_0000;
            dmaWr    <= 1'b0;
        end else begin
            serRd <= 1'b0;
            serWr <= 1'b0;
            ethRd <= 1'b0;
            ethWr <= 1'b0;
            dmaWr <= 1'b0;
            ioAck <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (ioReq) begin
                        state    <= ST_ACCESS;
                        curWrite <= ioWrite;
                        curAddr  <= ioAddr;
                        curWdata <= ioWdata;
                        case (ioAddr[`NAR_GRP_MSB:`NAR_GRP_LSB])
                            `NAR_GRP_SERIAL: begin
                                serAddr  <= ioAddr[`NAR_SUB_MSB:0];
                                serWdata <= ioWdata[7:0];
                                serRd    <= !ioWrite;
                                serWr    <= ioWrite;
                            end
                            `NAR_GRP_ETH_CTRL: begin
                                ethAddr  <= ioAddr[`NAR_ETH_SEL_MSB:0];
                                ethWdata <= ioWdata[7:0];
                                ethRd    <= !ioWrite;
                                ethWr    <= ioWrite;
                            end
                            `NAR_GRP_DMA: begin
                                dmaSel   <= ioAddr[`NAR_DMA_SEL_MSB:0];
                                dmaWdata <= ioWdata;
                                dmaWr    <= ioWrite;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_ACCESS: begin
                    state   <= ST_DONE;
                    ioAck   <= 1'b1;
                    ioRdata <= curWrite ? 32'h0000_0000 : rdMux;
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // read data, sampled in the strobe cycle; writes to read-only groups just ack
    always @* begin
        case (grp)
            `NAR_GRP_BOARD_IDENTIFIER: rdMux = BOARD_IDENTIFIER;
            `NAR_GRP_ADDR_ROM: rdMux = {24'h00_0000, romByte};
            `NAR_GRP_STATUS:   rdMux = statusWord;
            `NAR_GRP_SERIAL:   rdMux = {24'h00_0000, serRdata};
            `NAR_GRP_ETH_CTRL: begin
                // station address bytes are write-only
                if (ethAddr == `NAR_ETH_RX_STATUS || ethAddr == `NAR_ETH_TX_STATUS)
                    rdMux = {24'h00_0000, ethRdata};
                else
                    rdMux = 32'h0000_0000;
            end
            `NAR_GRP_DMA:      rdMux = dmaRdata;
            default:           rdMux = 32'h0000_0000;
        endcase
    end

    // control field is the only writable part of the status word
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl      <= `NAR_CTRL_RESET;
            termReady <= 8'h00;
            txCommand <= 8'h00;
        end else if (inAccess && curWrite) begin
            if (grp == `NAR_GRP_STATUS)
                ctrl <= curWdata[`NAR_CTRL_BYTESEQ:`NAR_CTRL_RXEN];
            if (grp == `NAR_GRP_TERM_READY)
                termReady <= curWdata[7:0];
            // shadow of the transmit mask, needed to judge error events
            if (grp == `NAR_GRP_ETH_CTRL && ethAddr == `NAR_ETH_TX_STATUS)
                txCommand <= curWdata[7:0];
        end
    end

    // status copies from the ethernet controller
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txStatCopy <= `NAR_STAT_RESET;
            rxStatCopy <= `NAR_STAT_RESET;
            ethIrqLast <= 1'b0;
        end else begin
            ethIrqLast <= ethIrq;
            if (ethIrqRise || ethStatRead) begin
                txStatCopy <= ethTxStat;
                rxStatCopy <= ethRxStat;
            end
        end
    end

    // interrupt flags; an event in the clearing cycle survives the clear
    always @* begin
        next_ints = statusRead ? `NAR_INTS_RESET : ints;
        if (txAttemptEnd && txGo && txFatal)
            next_ints[`NAR_INT_TX] = 1'b1;
        if (rxDoneLate)
            next_ints[`NAR_INT_RX] = 1'b1;
        // only cycles that bring bus data in are judged
        if (ioParityBad && (take || dmaRdValid))
            next_ints[`NAR_INT_PARITY] = 1'b1;
        if (serIrq)
            next_ints[`NAR_INT_SERIAL] = 1'b1;
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ints   <= `NAR_INTS_RESET;
            busIrq <= 1'b0;
        end else begin
            ints   <= next_ints;
            busIrq <= |next_ints;
        end
    end

    // transmit and receive sequencing seen by the dma engines
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txFinished    <= 1'b0;
            txGo          <= 1'b0;
            dmaHalt       <= 1'b0;
            dmaRestart    <= 1'b0;
            rxDoneLate    <= 1'b0;
            rxAccept      <= 1'b0;
            byteSeqSelect <= 1'b0;
            loopback      <= 1'b1;
            xcvrEnable    <= 1'b0;
            rxEndStatus   <= `NAR_STAT_RESET;
            rxEndReadPtr  <= `NAR_PTR_RESET;
        end else begin
            dmaHalt    <= txAttemptEnd && txGo && txFatal;
            dmaRestart <= txAttemptEnd && txGo && !txFatal && txErrEvent;

            // after the one packet stay idle until software drops the enable
            if (!ctrl[`NAR_CTRL_TXEN - `NAR_CTRL_RXEN])
                txFinished <= 1'b0;
            else if (txDone)
                txFinished <= 1'b1;
            txGo <= ctrl[`NAR_CTRL_TXEN - `NAR_CTRL_RXEN] && !txFinished
                    && !txDone;

            // flag one cycle after the pointer moves
            rxDoneLate <= readAdv;
            rxAccept   <= ctrl[`NAR_CTRL_RXEN - `NAR_CTRL_RXEN] && !qEmpty;

            byteSeqSelect <= ctrl[`NAR_CTRL_BYTESEQ - `NAR_CTRL_RXEN];
            xcvrEnable    <= ctrl[`NAR_CTRL_XCVR - `NAR_CTRL_RXEN];
            loopback      <= !ctrl[`NAR_CTRL_XCVR - `NAR_CTRL_RXEN];
            rxEndStatus   <= rxStatCopy;
            rxEndReadPtr  <= readPtr;
        end
    end

    // full is informative only; software keeps at most fifteen descriptors
    wire unusedFull;
    assign unusedFull = qFull;
endmodule
